/* design/mdsu_cmd_if.sv */
// mdsu_cmd_if: decoded command and operands between decoder and datapath
// assumes a single core clock domain
`timescale 1ns/1ns
interface mdsu_cmd_if;
  mdsu_pkg::mdsu_cmd_e cmd;
  logic                valid;
  logic [31:0]         src_a;
  logic [31:0]         src_b;
  modport dec (output cmd, output valid, output src_a, output src_b);
  modport dp  (input cmd, input valid, input src_a, input src_b);
endinterface

/* design/mdsu_decode.sv */
// mdsu_decode: maps a 16-bit instruction word onto a datapath command
// assumes operand values are already read from the register file
`timescale 1ns/1ns
module mdsu_decode (
  input  wire logic [15:0] instr_in,
  input  wire logic        instr_valid_in,
  input  wire logic [31:0] dest_or_divisor_reg_in,
  input  wire logic [31:0] source_reg_in,
  mdsu_cmd_if.dec          cmd_if
);
  // pure decode; unknown patterns yield no command
  always_comb
  begin
    cmd_if.cmd = mdsu_pkg::MDSU_NONE;
    if (instr_in == mdsu_pkg::OP_SIGN_FIX)
      cmd_if.cmd = mdsu_pkg::MDSU_SFIX;
    else if (instr_in == mdsu_pkg::OP_DIV_QFIX)
      cmd_if.cmd = mdsu_pkg::MDSU_QFIX;
    else if (instr_in[15:8] == mdsu_pkg::OP_MUL_S)
      cmd_if.cmd = mdsu_pkg::MDSU_MULS;
    else if (instr_in[15:8] == mdsu_pkg::OP_MUL_U)
      cmd_if.cmd = mdsu_pkg::MDSU_MULU;
    else if (instr_in[15:4] == mdsu_pkg::OP_DIV_SSET)
      cmd_if.cmd = mdsu_pkg::MDSU_SSET;
    else if (instr_in[15:4] == mdsu_pkg::OP_DIV_USET)
      cmd_if.cmd = mdsu_pkg::MDSU_USET;
    else if (instr_in[15:4] == mdsu_pkg::OP_DIV_STEP)
      cmd_if.cmd = mdsu_pkg::MDSU_STEP;
    else if (instr_in[15:4] == mdsu_pkg::OP_DIV_REMFIX)
      cmd_if.cmd = mdsu_pkg::MDSU_REMF;
  end

  // operands pass straight through
  assign cmd_if.valid = instr_valid_in && (cmd_if.cmd != mdsu_pkg::MDSU_NONE);
  assign cmd_if.src_a = dest_or_divisor_reg_in;
  assign cmd_if.src_b = source_reg_in;
endmodule

/* design/mdsu_mult.sv */
// mdsu_mult: 16x16 halfword multiplier, signed or unsigned
// assumes operands held stable by the caller for the whole operation
`timescale 1ns/1ns
module mdsu_mult (
  input  wire logic [15:0] a_in,
  input  wire logic [15:0] b_in,
  input  wire logic        signed_in,
  output logic      [31:0] prod_out
);
  logic signed [16:0] a_x;
  logic signed [16:0] b_x;
  logic signed [33:0] p_x;
  // one extra bit carries the sign or zero extension
  always_comb
  begin
    a_x      = {signed_in & a_in[15], a_in};
    b_x      = {signed_in & b_in[15], b_in};
    p_x      = a_x * b_x;
    prod_out = p_x[31:0];
  end
endmodule

/* design/mdsu_pkg.sv */
// mdsu_pkg: opcodes, command codes, timing and reset values for the multiply/divide unit
// assumes a 16-bit instruction word supplied by the core decoder
package mdsu_pkg;
  localparam int unsigned WORD_W        = 32;
  localparam int unsigned HALF_W        = 16;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // halfword multiply takes three core cycles
  localparam int unsigned MUL_CYCLES    = 3;
  // interlock after a divide step when product is read next
  localparam int unsigned STEP_LOCK_CYC = 2;
  localparam logic [31:0] PROD_RST      = 32'h0000_0000;
  localparam logic [15:0] OP_SIGN_FIX   = 16'h9F70;
  localparam logic [7:0]  OP_MUL_S      = 8'hBF;
  localparam logic [7:0]  OP_MUL_U      = 8'hBB;
  localparam logic [11:0] OP_DIV_SSET   = 12'h974;
  localparam logic [11:0] OP_DIV_USET   = 12'h975;
  localparam logic [11:0] OP_DIV_STEP   = 12'h976;
  localparam logic [11:0] OP_DIV_REMFIX = 12'h977;
  localparam logic [15:0] OP_DIV_QFIX   = 16'h9F60;

  typedef enum logic [3:0] {
    MDSU_NONE = 4'h0, MDSU_MULS = 4'h1, MDSU_MULU = 4'h2, MDSU_SSET = 4'h3,
    MDSU_USET = 4'h4, MDSU_STEP = 4'h5, MDSU_REMF = 4'h6, MDSU_QFIX = 4'h7,
    MDSU_SFIX = 4'h8
  } mdsu_cmd_e;
endpackage

/* design/mdsu_top.sv */
// mdsu_top: multiply / stepwise-divide datapath with product pair and division flags
// assumes the decoder holds instr and operands until busy drops; one core clock
// Behaviour
// - unsigned halfword multiply: low 16 bits unsigned, product to product_low
// - signed halfword multiply: low 16 bits signed, product to product_low
// - after multiply: N is product_low bit 31, Z when zero, V C kept
// - each halfword multiply completes in exactly MUL_LAT cycles, three by default
// - signed setup: flag0 gets dividend sign, flag1 gets sign xor
// - signed setup: product_high gets sign extension of product_low
// - unsigned setup clears product_high and both division flags
// - step shifts product pair left one, trial adds or subtracts divisor
// - step commits trial and sets quotient bit when flag0 xor flag1 xor carry is zero
// - step sets Z from trial, C from trial carry, N V kept
// - step one cycle, two-cycle interlock if product read follows
// - remainder fix forms trial, updates Z C, clears high if Z
// - quotient fix increments product_low when Z set, flags kept
// - sign fix negates product_low when flag1 set, flags kept
// - sign fix recognised by its fixed sixteen-bit pattern
// - setups and the three fixes each complete in one cycle
// - setups, quotient fix and sign fix leave N Z V C alone
`timescale 1ns/1ns
module mdsu_top #(
  parameter int unsigned MUL_LAT = mdsu_pkg::MUL_CYCLES
) (
  // clock and reset
  input  wire logic        CORE_CLK_IN,
  input  wire logic        SYS_RST_IN,
  // instruction and operands
  input  wire logic [15:0] INSTR_IN,
  input  wire logic        INSTR_VALID_IN,
  input  wire logic [31:0] DEST_OR_DIVISOR_REG_IN,
  input  wire logic [31:0] SOURCE_REG_IN,
  input  wire logic        NEXT_READS_PRODUCT_IN,
  // condition code register in
  input  wire logic [3:0]  CCR_NZVC_IN,
  // results
  output logic [31:0]      PRODUCT_HIGH_OUT,
  output logic [31:0]      PRODUCT_LOW_OUT,
  output logic             DIVIDEND_SIGN_FLAG_OUT,
  output logic             SIGN_DIFFER_FLAG_OUT,
  output logic [3:0]       CCR_NZVC_OUT,
  output logic             CCR_WRITE_OUT,
  output logic             BUSY_OUT,
  output logic             DONE_OUT
);
  localparam int unsigned CW = 2;

  // elaboration check; only these latencies pass, though the two-bit down counter would serve up to 5
  if (MUL_LAT < 2 || MUL_LAT > 3)
  begin : g_bad_mul_lat
    $error("MUL_LAT out of range");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_MUL = 2'b01, ST_LOCK = 2'b10
  } mdsu_st_e;

  typedef struct packed {
    mdsu_st_e    st;
    logic [CW-1:0] cnt;
    logic [31:0] hi;
    logic [31:0] lo;
    logic        f0;
    logic        f1;
    logic [3:0]  condition_code_register;
    logic        ccr_wr;
    logic        busy;
    logic        done;
  } mdsu_state_s;

  mdsu_state_s q;
  mdsu_state_s d;

  mdsu_cmd_if cif ();

  mdsu_decode u_mdsu_decode (
    .instr_in               (INSTR_IN),
    .instr_valid_in         (INSTR_VALID_IN),
    .dest_or_divisor_reg_in (DEST_OR_DIVISOR_REG_IN),
    .source_reg_in          (SOURCE_REG_IN),
    .cmd_if                 (cif)
  );

  logic [31:0] mul_p;
  mdsu_mult u_mdsu_mult (
    .a_in      (cif.src_a[15:0]),
    .b_in      (cif.src_b[15:0]),
    .signed_in (cif.cmd == mdsu_pkg::MDSU_MULS),
    .prod_out  (mul_p)
  );

  logic [63:0] shl;
  logic [32:0] trial;
  logic [32:0] trial_r;
  logic        commit;

  // trial arithmetic; carry read as bit 32 of the 33-bit sum or difference
  always_comb
  begin
    shl = {q.hi, q.lo} << 1;
    trial = q.f1 ? ({1'b0, shl[63:32]} + {1'b0, cif.src_a})
                 : ({1'b0, shl[63:32]} - {1'b0, cif.src_a});
    trial_r = q.f1 ? ({1'b0, q.hi} + {1'b0, cif.src_a})
                   : ({1'b0, q.hi} - {1'b0, cif.src_a});
    commit = ~(q.f0 ^ q.f1 ^ trial[32]);
  end

  // next-state: one case per command, the two multiplies sharing one, flags only touched where stated
  always_comb
  begin
    d        = q;
    d.done   = 1'b0;
    d.ccr_wr = 1'b0;
    case (q.st)
      ST_IDLE:
      begin
        d.busy = 1'b0;
        if (cif.valid)
        begin
          d.condition_code_register = CCR_NZVC_IN;
          case (cif.cmd)
            mdsu_pkg::MDSU_MULS, mdsu_pkg::MDSU_MULU:
            begin
              d.st   = ST_MUL;
              d.cnt  = CW'(MUL_LAT - 2);
              d.busy = 1'b1;
            end
            mdsu_pkg::MDSU_SSET:
            begin
              d.f0   = q.lo[31];
              d.f1   = q.lo[31] ^ cif.src_a[31];
              d.hi   = {32{q.lo[31]}};
              d.done = 1'b1;
            end
            mdsu_pkg::MDSU_USET:
            begin
              d.f0   = 1'b0;
              d.f1   = 1'b0;
              d.hi   = mdsu_pkg::PROD_RST;
              d.done = 1'b1;
            end
            mdsu_pkg::MDSU_STEP:
            begin
              d.hi     = commit ? trial[31:0] : shl[63:32];
              d.lo     = {shl[31:1], commit};
              d.condition_code_register[2] = (trial[31:0] == 32'h0000_0000);
              d.condition_code_register[0] = trial[32];
              d.ccr_wr = 1'b1;
              if (NEXT_READS_PRODUCT_IN)
              begin
                d.st   = ST_LOCK;
                d.cnt  = CW'(mdsu_pkg::STEP_LOCK_CYC - 1);
                d.busy = 1'b1;
              end
              else
                d.done = 1'b1;
            end
            mdsu_pkg::MDSU_REMF:
            begin
              d.condition_code_register[2] = (trial_r[31:0] == 32'h0000_0000);
              d.condition_code_register[0] = trial_r[32];
              d.ccr_wr = 1'b1;
              if (trial_r[31:0] == 32'h0000_0000)
                d.hi = mdsu_pkg::PROD_RST;
              d.done = 1'b1;
            end
            mdsu_pkg::MDSU_QFIX:
            begin
              if (CCR_NZVC_IN[2])
                d.lo = q.lo + 32'h0000_0001;
              d.done = 1'b1;
            end
            mdsu_pkg::MDSU_SFIX:
            begin
              if (q.f1)
                d.lo = 32'h0000_0000 - q.lo;
              d.done = 1'b1;
            end
            default:
              d.done = 1'b0;
          endcase
        end
      end
      ST_MUL:
      begin
        if (q.cnt == '0)
        begin
          d.lo     = mul_p;
          d.condition_code_register[3] = mul_p[31];
          d.condition_code_register[2] = (mul_p == 32'h0000_0000);
          d.ccr_wr = 1'b1;
          d.done   = 1'b1;
          d.busy   = 1'b0;
          d.st     = ST_IDLE;
        end
        else
          d.cnt = q.cnt - CW'(1);
      end
      ST_LOCK:
      begin
        if (q.cnt == '0)
        begin
          d.busy = 1'b0;
          d.done = 1'b1;
          d.st   = ST_IDLE;
        end
        else
          d.cnt = q.cnt - CW'(1);
      end
      default:
        d.st = ST_IDLE;
    endcase
  end

  // state register; division flags persist until a setup rewrites them
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      q <= '0;
    else
      q <= d;
  end

  // outputs straight from the state flops
  assign PRODUCT_HIGH_OUT       = q.hi;
  assign PRODUCT_LOW_OUT        = q.lo;
  assign DIVIDEND_SIGN_FLAG_OUT = q.f0;
  assign SIGN_DIFFER_FLAG_OUT   = q.f1;
  assign CCR_NZVC_OUT           = q.condition_code_register;
  assign CCR_WRITE_OUT          = q.ccr_wr;
  assign BUSY_OUT               = q.busy;
  assign DONE_OUT               = q.done;

  // busy without done: the wait cycles of a multiply or of a step interlock
  logic busy_chk;
  assign busy_chk = BUSY_OUT && !DONE_OUT;

  // multiply done exactly three cycles after acceptance, default latency
  sequence s_mul_issue;
    q.st == ST_IDLE && cif.valid &&
      (cif.cmd == mdsu_pkg::MDSU_MULS || cif.cmd == mdsu_pkg::MDSU_MULU);
  endsequence
  property p_mul_lat;
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      s_mul_issue |-> ##1 busy_chk[*2] ##0 1'b1 ##1 DONE_OUT;
  endproperty
  a_mul_lat: assert property (p_mul_lat) else $error("multiply latency wrong");

  property p_mul_flags;
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (q.st == ST_MUL && q.cnt == '0) |=> CCR_NZVC_OUT[3] == PRODUCT_LOW_OUT[31] &&
        CCR_NZVC_OUT[2] == (PRODUCT_LOW_OUT == 32'h0000_0000) &&
        CCR_NZVC_OUT[1:0] == $past(q.condition_code_register[1:0]);
  endproperty
  a_mul_flags: assert property (p_mul_flags) else $error("multiply flags wrong");

  property p_sset;
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (q.st == ST_IDLE && cif.valid && cif.cmd == mdsu_pkg::MDSU_SSET) |=>
        DIVIDEND_SIGN_FLAG_OUT == $past(q.lo[31]) &&
        SIGN_DIFFER_FLAG_OUT == ($past(q.lo[31]) ^ $past(cif.src_a[31])) &&
        PRODUCT_HIGH_OUT == {32{$past(q.lo[31])}} && DONE_OUT && !CCR_WRITE_OUT;
  endproperty
  a_sset: assert property (p_sset) else $error("signed setup wrong");

  property p_uset;
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (q.st == ST_IDLE && cif.valid && cif.cmd == mdsu_pkg::MDSU_USET) |=>
        PRODUCT_HIGH_OUT == 32'h0000_0000 && !DIVIDEND_SIGN_FLAG_OUT &&
        !SIGN_DIFFER_FLAG_OUT && $stable(PRODUCT_LOW_OUT);
  endproperty
  a_uset: assert property (p_uset) else $error("unsigned setup wrong");

  property p_step_lock;
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (q.st == ST_IDLE && cif.valid && cif.cmd == mdsu_pkg::MDSU_STEP &&
       NEXT_READS_PRODUCT_IN) |=> BUSY_OUT ##1 BUSY_OUT ##1 (DONE_OUT && !BUSY_OUT);
  endproperty
  a_step_lock: assert property (p_step_lock) else $error("step interlock wrong");

  property p_step_q;
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (q.st == ST_IDLE && cif.valid && cif.cmd == mdsu_pkg::MDSU_STEP) |=>
        PRODUCT_LOW_OUT[31:1] == $past(q.lo[30:0]) && PRODUCT_LOW_OUT[0] == $past(commit)
        && CCR_NZVC_OUT[0] == $past(trial[32]) && CCR_WRITE_OUT;
  endproperty
  a_step_q: assert property (p_step_q) else $error("divide step wrong");

  property p_qfix;
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (q.st == ST_IDLE && cif.valid && cif.cmd == mdsu_pkg::MDSU_QFIX) |=>
        PRODUCT_LOW_OUT == $past(q.lo) + {31'h0, $past(CCR_NZVC_IN[2])} && !CCR_WRITE_OUT;
  endproperty
  a_qfix: assert property (p_qfix) else $error("quotient fix wrong");

  property p_sfix;
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (q.st == ST_IDLE && cif.valid && cif.cmd == mdsu_pkg::MDSU_SFIX && q.f1) |=>
        PRODUCT_LOW_OUT == 32'h0000_0000 - $past(q.lo) && DONE_OUT;
  endproperty
  a_sfix: assert property (p_sfix) else $error("sign fix wrong");
endmodule

/* tb/mdsu_issuer_model.sv */
// mdsu_issuer_model: decoder and register-file stand-in that feeds the datapath
// assumes one core clock; keeps the core's own copy of the condition codes
`timescale 1ns/1ns
module mdsu_issuer_model (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // datapath answers
  input  wire logic        done_in,
  input  wire logic        ccr_write_in,
  input  wire logic [3:0]  ccr_nzvc_in,
  // instruction side
  output logic      [15:0] instr_out,
  output logic             valid_out,
  output logic      [31:0] ri_out,
  output logic      [31:0] rj_out,
  output logic             nrp_out,
  output logic      [3:0]  ccr_out
);
  // known idle values at time zero
  initial
  begin
    instr_out = 16'h0000;
    valid_out = 1'b0;
    ri_out    = 32'h0000_0000;
    rj_out    = 32'h0000_0000;
    nrp_out   = 1'b0;
  end

  // core copy of nzvc, taken only on a write pulse
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      ccr_out <= 4'h0;
    else if (ccr_write_in === 1'b1)
      ccr_out <= ccr_nzvc_in;
  end

  // one instruction: strobe for one edge, hold operands until done, then scramble
  task automatic issue(input logic [15:0] op, input logic [31:0] ri, input logic [31:0] rj,
                       input logic nrp, output int lat);
    @(posedge clk_in);
    instr_out <= op;
    valid_out <= 1'b1;
    ri_out    <= ri;
    rj_out    <= rj;
    nrp_out   <= nrp;
    @(posedge clk_in);
    valid_out <= 1'b0;
    lat = 0;
    for (int n = 1; n <= 8 && lat == 0; n++)
    begin
      @(negedge clk_in);
      if (done_in === 1'b1)
        lat = n;
    end
    // released lines show the inverse, so stale values never pass for held ones
    @(posedge clk_in);
    instr_out <= ~op;
    ri_out    <= ~ri;
    rj_out    <= ~rj;
    nrp_out   <= ~nrp;
    @(negedge clk_in);
  endtask

  // overwrite the core flags while the datapath is idle
  task automatic set_ccr(input logic [3:0] v);
    @(posedge clk_in);
    ccr_out <= v;
    @(negedge clk_in);
  endtask

  // steps and corrections after a setup, same divisor every time
  task automatic finish_divide(input logic sgn, input logic [31:0] dvs);
    int lat;
    repeat (32) issue({mdsu_pkg::OP_DIV_STEP, 4'h2}, dvs, 32'h0, 1'b0, lat);
    if (sgn)
    begin
      issue({mdsu_pkg::OP_DIV_REMFIX, 4'h2}, dvs, 32'h0, 1'b0, lat);
      issue(mdsu_pkg::OP_DIV_QFIX, 32'h0, 32'h0, 1'b0, lat);
      issue(mdsu_pkg::OP_SIGN_FIX, 32'h0, 32'h0, 1'b0, lat);
    end
  endtask
endmodule

/* tb/mdsu_top_test.sv */
// mdsu_top_test: self-checking bench for the multiply / stepwise-divide datapath
// assumes the issuer model drives every instruction-side input
`timescale 1ns/1ns
module mdsu_top_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] instr;
  logic        valid;
  logic [31:0] ri;
  logic [31:0] rj;
  logic        nrp;
  logic [3:0]  condition_code_register;
  logic [31:0] prod_hi;
  logic [31:0] prod_lo;
  logic        fl0;
  logic        fl1;
  logic [3:0]  nzvc;
  logic        ccr_wr;
  logic        busy;
  logic        done;
  int          errors = 0;
  int          tests_run = 0;
  int          lat;
  int          busy_cyc = 0;

  // 50 MHz core clock
  always #10 clk = ~clk;

  // busy cycles seen by the core; checked against the stated wait spans
  always @(posedge clk)
    if (busy === 1'b1)
      busy_cyc <= busy_cyc + 1;

  mdsu_top u_mdsu_top (
    .CORE_CLK_IN(clk), .SYS_RST_IN(rst), .INSTR_IN(instr), .INSTR_VALID_IN(valid),
    .DEST_OR_DIVISOR_REG_IN(ri), .SOURCE_REG_IN(rj), .NEXT_READS_PRODUCT_IN(nrp),
    .CCR_NZVC_IN(condition_code_register), .PRODUCT_HIGH_OUT(prod_hi), .PRODUCT_LOW_OUT(prod_lo),
    .DIVIDEND_SIGN_FLAG_OUT(fl0), .SIGN_DIFFER_FLAG_OUT(fl1), .CCR_NZVC_OUT(nzvc),
    .CCR_WRITE_OUT(ccr_wr), .BUSY_OUT(busy), .DONE_OUT(done));

  mdsu_issuer_model u_mdsu_issuer_model (
    .clk_in(clk), .rst_in(rst), .done_in(done), .ccr_write_in(ccr_wr), .ccr_nzvc_in(nzvc),
    .instr_out(instr), .valid_out(valid), .ri_out(ri), .rj_out(rj), .nrp_out(nrp),
    .ccr_out(condition_code_register));

  // one comparison, counted, mismatch reported at once
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // expected low product word; sign-extended operands give the signed product
  function automatic logic [31:0] mulx(input logic sgn, input logic [15:0] a, b);
    return sgn ? {{16{a[15]}}, a} * {{16{b[15]}}, b} : {16'h0, a} * {16'h0, b};
  endfunction

  // bit-exact walk of setup, 32 steps and the signed corrections
  function automatic void emu(input logic sgn, input logic [31:0] dvd, dvs,
                              input logic [3:0] cin, output logic [63:0] res,
                              output logic [3:0] cout);
    logic        d0;
    logic        d1;
    logic [32:0] t;
    logic [31:0] h;
    logic [31:0] l;
    d0 = sgn & dvd[31];
    d1 = sgn & (dvd[31] ^ dvs[31]);
    h = {32{d0}};
    l = dvd;
    cout = cin;
    // unsigned runs stop after the last step; signed ones add the remainder fix
    for (int i = 0; i < (sgn ? 33 : 32); i++)
    begin
      if (i < 32)
        {h, l} = {h, l} << 1;
      t = d1 ? {1'b0, h} + {1'b0, dvs} : {1'b0, h} - {1'b0, dvs};
      cout[2] = (t[31:0] == 32'h0);
      cout[0] = t[32];
      if (i < 32 && (d0 ^ d1 ^ t[32]) == 1'b0)
      begin
        h = t[31:0];
        l[0] = 1'b1;
      end
    end
    if (sgn)
    begin
      h = cout[2] ? 32'h0 : h;
      l = cout[2] ? l + 32'h1 : l;
      l = d1 ? 32'h0 - l : l;
    end
    res = {h, l};
  endfunction

  // halfword multiply with junk in the upper operand halves
  task automatic do_mul(input logic sgn, input logic [15:0] a, b);
    logic [31:0] e;
    int          b0;
    e = mulx(sgn, a, b);
    b0 = busy_cyc;
    u_mdsu_issuer_model.set_ccr(4'h3);
    u_mdsu_issuer_model.issue({sgn ? mdsu_pkg::OP_MUL_S : mdsu_pkg::OP_MUL_U, 8'h23},
                              {16'hABCD, a}, {16'h5A5A, b}, 1'b0, lat);
    chk(prod_lo, e);
    chk(condition_code_register, {e[31], e == 32'h0, 2'b11});
    chk(lat, 3);
    chk(busy_cyc - b0, mdsu_pkg::MUL_CYCLES - 1);
  endtask

  // full division on a dividend loaded by a multiply
  task automatic do_div(input logic sgn, input logic [15:0] a, b, input logic [31:0] dvs);
    logic [31:0] dvd;
    logic [63:0] res;
    logic [3:0]  c;
    dvd = mulx(sgn, a, b);
    do_mul(sgn, a, b);
    u_mdsu_issuer_model.set_ccr(4'h2);
    u_mdsu_issuer_model.issue({sgn ? mdsu_pkg::OP_DIV_SSET : mdsu_pkg::OP_DIV_USET, 4'h2},
                              dvs, 32'h0, 1'b0, lat);
    chk(lat, 1);
    chk({fl0, fl1}, {sgn & dvd[31], sgn & (dvd[31] ^ dvs[31])});
    chk(prod_hi, {32{sgn & dvd[31]}});
    chk(condition_code_register, 4'h2);
    emu(sgn, dvd, dvs, 4'h2, res, c);
    u_mdsu_issuer_model.finish_divide(sgn, dvs);
    chk({prod_hi, prod_lo}, res);
    chk(condition_code_register, c);
    chk({fl0, fl1}, {sgn & dvd[31], sgn & (dvd[31] ^ dvs[31])});
  endtask

  // corrections alone, an unknown pattern and the step interlock
  task automatic t_misc;
    int b0;
    do_mul(1'b0, 16'h0010, 16'h0001);
    u_mdsu_issuer_model.issue({mdsu_pkg::OP_DIV_SSET, 4'h2}, 32'hFFFF_FFFF, 32'h0, 1'b0, lat);
    u_mdsu_issuer_model.set_ccr(4'h4);
    u_mdsu_issuer_model.issue(mdsu_pkg::OP_DIV_QFIX, 32'h0, 32'h0, 1'b0, lat);
    chk({prod_lo, condition_code_register, 8'(lat)}, {32'h11, 4'h4, 8'h1});
    u_mdsu_issuer_model.issue(mdsu_pkg::OP_SIGN_FIX, 32'h0, 32'h0, 1'b0, lat);
    chk({prod_lo, condition_code_register, 8'(lat)}, {32'hFFFF_FFEF, 4'h4, 8'h1});
    u_mdsu_issuer_model.issue(16'h9F71, 32'h0, 32'h0, 1'b0, lat);
    chk({prod_lo, 8'(lat)}, {32'hFFFF_FFEF, 8'h0});
    u_mdsu_issuer_model.set_ccr(4'h0);
    u_mdsu_issuer_model.issue(mdsu_pkg::OP_DIV_QFIX, 32'h0, 32'h0, 1'b0, lat);
    chk(prod_lo, 32'hFFFF_FFEF);
    b0 = busy_cyc;
    u_mdsu_issuer_model.issue({mdsu_pkg::OP_DIV_STEP, 4'h2}, 32'h3, 32'h0, 1'b1, lat);
    chk(lat, 3);
    chk(busy_cyc - b0, mdsu_pkg::STEP_LOCK_CYC);
    u_mdsu_issuer_model.issue({mdsu_pkg::OP_DIV_STEP, 4'h2}, 32'h3, 32'h0, 1'b0, lat);
    chk(lat, 1);
    $display("test misc done");
  endtask

  // verdict and the only way out
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog: runs take well under 3000 cycles
  initial
  begin
    #(20 * 20000);
    errors++;
    end_sim();
  end

  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    do_mul(1'b0, 16'hFFFF, 16'hFFFF);
    do_mul(1'b1, 16'hFFFF, 16'h0002);
    do_mul(1'b1, 16'h8000, 16'h8000);
    do_mul(1'b0, 16'h0000, 16'h0005);
    $display("test mul done");
    do_div(1'b0, 16'hFFFF, 16'hFFFF, 32'h0000_1234);
    do_div(1'b0, 16'h0005, 16'h0001, 32'h0000_0007);
    do_div(1'b1, 16'h8000, 16'h0001, 32'h0000_0007);
    do_div(1'b1, 16'h0064, 16'h0001, 32'hFFFF_FFF9);
    do_div(1'b1, 16'hFFD6, 16'h0001, 32'hFFFF_FFFA);
    do_div(1'b1, 16'hFFD6, 16'h0001, 32'h0000_0007);
    $display("test div done");
    t_misc();
    end_sim();
  end
endmodule
